// [hdl/amt_defs.vh]
// amt_defs.vh: constants for the auto/manual transfer block
// assumes 16-bit signed values scaled so that 100.00 equals 10000 counts
`ifndef AMT_DEFS_VH
`define AMT_DEFS_VH
// ----------------------------------------------------------------
// value format and default range
// ----------------------------------------------------------------
`define AMT_VW 16
`define AMT_RANGE_LO_DEF 16'sh0000
`define AMT_RANGE_HI_DEF 16'sh2710
// ----------------------------------------------------------------
// startup
// ----------------------------------------------------------------
`define AMT_START_MAN_SCANS 2'h2
// ----------------------------------------------------------------
// knob step per detent, by acceleration code
// ----------------------------------------------------------------
`define AMT_ACCL_SLOW 2'h0
`define AMT_ACCL_MED 2'h1
`define AMT_ACCL_FAST 2'h2
`define AMT_STEP_SLOW 16'h0001
`define AMT_STEP_MED 16'h000a
`define AMT_STEP_FAST 16'h0064
// ----------------------------------------------------------------
// register map (word addresses are byte offsets / 4)
// ----------------------------------------------------------------
`define AMT_REG_CTRL 4'h0
`define AMT_REG_CFG 4'h1
`define AMT_REG_PUMAN 4'h2
`define AMT_REG_MANVAL 4'h3
`define AMT_REG_STATUS 4'h4
`define AMT_REG_OUT 4'h5
`define AMT_REG_PRIO 4'h6
// ctrl bits (write one to act)
`define AMT_CTRL_AUTO 0
`define AMT_CTRL_MAN 1
`define AMT_CTRL_ACK_EM 2
`define AMT_CTRL_ACK_SB 3
// cfg bits
`define AMT_CFG_AUTO_ONLY 0
`define AMT_CFG_RESTORE 1
`define AMT_CFG_POWERUP_MANUAL_VALUE 2
`define AMT_CFG_CW_INC 3
`define AMT_CFG_EM_FOLLOW 4
`define AMT_CFG_LOCK 5
`define AMT_CFG_RANGE_EN 6
`define AMT_CFG_ACCL_LO 8
`define AMT_CFG_RESET 16'h0008
`define AMT_PRIO_RESET 8'h00
`endif

// [hdl/amt_event.v]
// amt_event.v: one display event with priority-dependent flashing
// assumes active and ack come from logic on the same clock
`timescale 1ns/1ps
module amt_event (
  // clock and reset
  input wire CLK_I,
  input wire SYS_RST_I,
  // event
  input wire active_i,
  input wire ack_i,
  input wire [2:0] prio_i,
  // display
  output reg flash_bar_o,
  output reg flash_led_o,
  output reg steady_led_o
);
  // ----------------------------------------------------------------
  // flash latch
  // ----------------------------------------------------------------
  reg flash_reg; // flashing pending until acknowledged
  reg act_dly_reg; // previous activity, for rise detection
  wire rise = active_i & ~act_dly_reg;
  wire flashing = (prio_i >= 3'h1) && (prio_i <= 3'h4);
  // odd priorities only clear on ack, even also on event end
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      flash_reg <= 1'b0;
      act_dly_reg <= 1'b0;
    end else begin
      act_dly_reg <= active_i;
      if (rise && flashing) begin
        flash_reg <= 1'b1; // a new event wins over ack
      end else if (ack_i) begin
        flash_reg <= 1'b0;
      end else if (!prio_i[0] && !active_i) begin
        flash_reg <= 1'b0;
      end
    end
  end
  // registered display outputs
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      flash_bar_o <= 1'b0;
      flash_led_o <= 1'b0;
      steady_led_o <= 1'b0;
    end else begin
      flash_bar_o <= flash_reg & (prio_i <= 3'h2) & flashing;
      flash_led_o <= flash_reg & flashing;
      steady_led_o <= active_i & (prio_i == 3'h5);
    end
  end
endmodule

// [hdl/amt_clamp.v]
// amt_clamp.v: limits a value to -10%..110% of a range
// assumes range low is below range high; combinational
`timescale 1ns/1ps
`include "amt_defs.vh"
module amt_clamp (
  // range and value
  input wire signed [`AMT_VW-1:0] lo_i,
  input wire signed [`AMT_VW-1:0] hi_i,
  input wire signed [`AMT_VW+1:0] val_i,
  // result
  output reg signed [`AMT_VW-1:0] val_o
);
  // ----------------------------------------------------------------
  // limits, widened so the margins never overflow
  // ----------------------------------------------------------------
  reg signed [`AMT_VW+1:0] span;
  reg signed [`AMT_VW+1:0] tenth;
  reg signed [`AMT_VW+1:0] lim_lo;
  reg signed [`AMT_VW+1:0] lim_hi;
  reg signed [`AMT_VW+1:0] sat;
  always @* begin
    span = {{2{hi_i[`AMT_VW-1]}}, hi_i} - {{2{lo_i[`AMT_VW-1]}}, lo_i};
    tenth = span / 18'sd10;
    lim_lo = {{2{lo_i[`AMT_VW-1]}}, lo_i} - tenth;
    lim_hi = {{2{hi_i[`AMT_VW-1]}}, hi_i} + tenth;
    if (val_i < lim_lo) begin
      sat = lim_lo;
    end else if (val_i > lim_hi) begin
      sat = lim_hi;
    end else begin
      sat = val_i;
    end
    // limits that leave the 16-bit word saturate at its ends
    if (sat > 18'sd32767) begin
      val_o = 16'sh7fff;
    end else if (sat < -18'sd32768) begin
      val_o = 16'sh8000;
    end else begin
      val_o = sat[`AMT_VW-1:0];
    end
  end
endmodule

// [hdl/amt_top.v]
// amt_top.v: auto/manual transfer for one loop, one scan per scan strobe
// assumes a classic Wishbone master on CLK_I and pins for emergency/track
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "amt_defs.vh"
// Contract
// - auto passes controller input unless emergency/standby
// - auto-only locks selector in auto
// - manual value follows output in auto/standby
// - clamp manual to -10%..110% of range
// - no range input means 0..100
// - emergency freezes output, allows manual, raises event
// - track command: standby follows track variable, event
// - auto status high when output is auto
// - not-auto high when output not auto
// - manual, emergency, standby status outputs
// - warm restore brings back outputs and selection
// - coming up in auto runs two manual scans
// - cold or plain warm uses power-up selection
// - power-up manual loads power-up manual value
// - clockwise raises value unless configured otherwise
// - emergency-follow forces selector to manual
// - emergency switch stays manual until condition clears
// - without follow, selector ignores emergency
// - manual lock refuses auto during emergency (here only while emergency-follow is also set)
// - knob acceleration slow, medium or fast
// - status outputs high at every priority
// - priority 1-4 flashing and its ending
// - priority 5 steady, priority 0 silent
module amt_top (
  // clock and reset
  input wire CLK_I,
  input wire SYS_RST_I,
  // wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [5:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  // start control
  input wire SCAN_I,
  input wire WARM_START_I,
  input wire COLD_START_I,
  // loop signals
  input wire signed [15:0] AUTO_IN_I,
  input wire signed [15:0] RANGE_LO_I,
  input wire signed [15:0] RANGE_HI_I,
  input wire EMERGENCY_INPUT_I,
  input wire TRACK_COMMAND_INPUT_I,
  input wire signed [15:0] TRACK_VARIABLE_INPUT_I,
  // faceplate
  input wire KNOB_STEP_I,
  input wire KNOB_CW_I,
  input wire AM_BUTTON_I,
  input wire ACK_BUTTON_I,
  // outputs
  output reg signed [15:0] BLOCK_OUTPUT_O,
  output reg AUTO_STATUS_OUT_O,
  output reg NOT_AUTO_OUT_O,
  output reg MANUAL_STATUS_OUT_O,
  output reg EMERGENCY_STATUS_OUT_O,
  output reg STANDBY_STATUS_OUT_O,
  output reg AUTO_LED_O,
  output reg MANUAL_LED_O,
  // event display
  output wire EM_FLASH_BAR_O,
  output wire EM_FLASH_LED_O,
  output wire EM_STEADY_LED_O,
  output wire SB_FLASH_BAR_O,
  output wire SB_FLASH_LED_O,
  output wire SB_STEADY_LED_O
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [6:0] sync1_reg; // first stage, read only by second
  reg [6:0] sync2_reg; // safe copies
  reg [2:0] edge_reg; // previous samples of button/knob/ack
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      edge_reg <= 3'h0;
    end else begin
      sync1_reg <= {ACK_BUTTON_I, AM_BUTTON_I, KNOB_CW_I, KNOB_STEP_I,
                    TRACK_COMMAND_INPUT_I, EMERGENCY_INPUT_I, SCAN_I};
      sync2_reg <= sync1_reg;
      edge_reg <= {sync2_reg[6], sync2_reg[5], sync2_reg[3]};
    end
  end
  wire scan_lvl = sync2_reg[0];
  wire em_in = sync2_reg[1];
  wire tc_in = sync2_reg[2];
  wire knob_cw = sync2_reg[4];
  wire knob_ev = sync2_reg[3] & ~edge_reg[0];
  wire am_ev = sync2_reg[5] & ~edge_reg[1];
  wire ack_ev = sync2_reg[6] & ~edge_reg[2];
  reg scan_dly_reg; // scan strobe edge finder
  wire scan = scan_lvl & ~scan_dly_reg;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] cfg_reg; // configuration bits
  reg signed [15:0] puman_reg; // power-up manual value
  reg [7:0] prio_reg; // [2:0] emergency, [6:4] standby priority
  reg signed [15:0] man_reg; // manual value
  reg sel_man_reg; // main selector in manual
  reg em_sw_reg; // emergency switch in manual
  reg sb_reg; // standby switch tracking
  reg [1:0] start_cnt_reg; // startup manual scans left
  reg cmd_auto_reg; // pending supervisory auto request
  reg cmd_man_reg; // pending supervisory manual request
  reg man_wr_reg; // pending supervisory manual value write
  reg signed [15:0] man_wr_val_reg; // value of that write
  reg [1:0] ack_sw_reg; // software acknowledge pulses
  reg am_pend_reg; // a/m press held for the next scan
  wire acc = CYC_I & STB_I & ~ACK_O;
  wire wr = acc & WE_I & SEL_I[0];
  wire [3:0] widx = ADR_I[5:2];
  // ----------------------------------------------------------------
  // range selection and clamp
  // ----------------------------------------------------------------
  wire rng = cfg_reg[`AMT_CFG_RANGE_EN];
  wire signed [15:0] r_lo = rng ? RANGE_LO_I : `AMT_RANGE_LO_DEF;
  wire signed [15:0] r_hi = rng ? RANGE_HI_I : `AMT_RANGE_HI_DEF;
  // knob step size by acceleration code
  function [15:0] step_of;
    input [1:0] code;
    begin
      case (code)
        `AMT_ACCL_MED: step_of = `AMT_STEP_MED;
        `AMT_ACCL_FAST: step_of = `AMT_STEP_FAST;
        default: step_of = `AMT_STEP_SLOW;
      endcase
    end
  endfunction
  wire [15:0] step = step_of(cfg_reg[`AMT_CFG_ACCL_LO+1:`AMT_CFG_ACCL_LO]);
  wire up = (knob_cw == cfg_reg[`AMT_CFG_CW_INC]);
  reg signed [17:0] man_cand;
  wire signed [15:0] man_clamped;
  wire signed [15:0] pu_clamped;
  amt_clamp u_clamp (
    .lo_i(r_lo),
    .hi_i(r_hi),
    .val_i(man_cand),
    .val_o(man_clamped)
  );
  amt_clamp u_clamp_pu (
    .lo_i(r_lo),
    .hi_i(r_hi),
    .val_i({{2{puman_reg[15]}}, puman_reg}),
    .val_o(pu_clamped)
  );
  // pending manual value; knob steps are only taken while not following, supervisory writes always
  wire following = ~sel_man_reg & ~em_sw_reg | sb_reg;
  always @* begin
    man_cand = {{2{man_reg[15]}}, man_reg};
    if (man_wr_reg) begin
      man_cand = {{2{man_wr_val_reg[15]}}, man_wr_val_reg};
    end else if (knob_ev && !following) begin
      if (up) begin
        man_cand = {{2{man_reg[15]}}, man_reg} + {2'h0, step};
      end else begin
        man_cand = {{2{man_reg[15]}}, man_reg} - {2'h0, step};
      end
    end
  end
  // ----------------------------------------------------------------
  // wishbone: one-cycle ack, control requests pend until the next scan
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      cfg_reg <= `AMT_CFG_RESET;
      puman_reg <= 16'sh0000;
      prio_reg <= `AMT_PRIO_RESET;
    end else begin
      ACK_O <= acc;
      if (wr && widx == `AMT_REG_CFG) begin
        cfg_reg <= DAT_I[15:0];
      end
      if (wr && widx == `AMT_REG_PUMAN) begin
        puman_reg <= DAT_I[15:0];
      end
      if (wr && widx == `AMT_REG_PRIO) begin
        prio_reg <= DAT_I[7:0] & 8'h77;
      end
      case (widx)
        `AMT_REG_CFG: DAT_O <= {16'h0000, cfg_reg};
        `AMT_REG_PUMAN: DAT_O <= {16'h0000, puman_reg};
        `AMT_REG_MANVAL: DAT_O <= {16'h0000, man_reg};
        `AMT_REG_STATUS: DAT_O <= {25'h0, MANUAL_LED_O, STANDBY_STATUS_OUT_O,
                                   EMERGENCY_STATUS_OUT_O, MANUAL_STATUS_OUT_O,
                                   NOT_AUTO_OUT_O, AUTO_STATUS_OUT_O, 1'b0};
        `AMT_REG_OUT: DAT_O <= {16'h0000, BLOCK_OUTPUT_O};
        `AMT_REG_PRIO: DAT_O <= {24'h0, prio_reg};
        default: DAT_O <= 32'h0000_0000; // ctrl and unmapped read zero
      endcase
    end
  end
  // supervisory requests wait for the next scan; a new request beats the clear
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cmd_auto_reg <= 1'b0;
      cmd_man_reg <= 1'b0;
      man_wr_reg <= 1'b0;
      man_wr_val_reg <= 16'sh0000;
      am_pend_reg <= 1'b0;
      ack_sw_reg <= 2'h0;
    end else begin
      ack_sw_reg <= 2'h0;
      if (wr && widx == `AMT_REG_CTRL) begin
        ack_sw_reg <= DAT_I[`AMT_CTRL_ACK_SB:`AMT_CTRL_ACK_EM];
      end
      if (wr && widx == `AMT_REG_CTRL && DAT_I[`AMT_CTRL_AUTO]) begin
        cmd_auto_reg <= 1'b1;
      end else if (scan) begin
        cmd_auto_reg <= 1'b0;
      end
      if (wr && widx == `AMT_REG_CTRL && DAT_I[`AMT_CTRL_MAN]) begin
        cmd_man_reg <= 1'b1;
      end else if (scan) begin
        cmd_man_reg <= 1'b0;
      end
      if (wr && widx == `AMT_REG_MANVAL) begin
        man_wr_reg <= 1'b1;
        man_wr_val_reg <= DAT_I[15:0];
      end else if (knob_ev || scan) begin
        man_wr_reg <= 1'b0;
      end
      if (am_ev) begin
        am_pend_reg <= 1'b1;
      end else if (scan) begin
        am_pend_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // scan evaluation: selection, output, status
  // ----------------------------------------------------------------
  wire auto_only = cfg_reg[`AMT_CFG_AUTO_ONLY];
  wire em_follow = cfg_reg[`AMT_CFG_EM_FOLLOW];
  wire lock = cfg_reg[`AMT_CFG_LOCK] & em_follow;
  wire want_auto = cmd_auto_reg | (am_pend_reg & sel_man_reg);
  wire want_man = cmd_man_reg | (am_pend_reg & ~sel_man_reg);
  wire start = WARM_START_I | COLD_START_I;
  wire restore = WARM_START_I & cfg_reg[`AMT_CFG_RESTORE];
  wire in_auto = ~sb_reg & ~em_sw_reg & ~sel_man_reg & (start_cnt_reg == 2'h0);
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      scan_dly_reg <= 1'b0;
      sel_man_reg <= 1'b1;
      em_sw_reg <= 1'b0;
      sb_reg <= 1'b0;
      start_cnt_reg <= 2'h0;
      man_reg <= 16'sh0000;
      BLOCK_OUTPUT_O <= 16'sh0000;
      AUTO_STATUS_OUT_O <= 1'b0;
      NOT_AUTO_OUT_O <= 1'b1;
      MANUAL_STATUS_OUT_O <= 1'b1;
      EMERGENCY_STATUS_OUT_O <= 1'b0;
      STANDBY_STATUS_OUT_O <= 1'b0;
      AUTO_LED_O <= 1'b0;
      MANUAL_LED_O <= 1'b1;
    end else begin
      scan_dly_reg <= scan_lvl;
      if (start) begin
        // warm restore keeps output, manual value and selector as they were
        if (restore) begin
          if (!sel_man_reg) begin
            start_cnt_reg <= `AMT_START_MAN_SCANS;
          end
        end else begin
          sel_man_reg <= cfg_reg[`AMT_CFG_POWERUP_MANUAL_VALUE];
          if (cfg_reg[`AMT_CFG_POWERUP_MANUAL_VALUE]) begin
            man_reg <= pu_clamped;
            BLOCK_OUTPUT_O <= pu_clamped;
          end else begin
            start_cnt_reg <= `AMT_START_MAN_SCANS;
          end
        end
        em_sw_reg <= 1'b0;
        sb_reg <= 1'b0;
      end else if (scan) begin
        if (start_cnt_reg != 2'h0) begin
          start_cnt_reg <= start_cnt_reg - 2'h1;
        end
        em_sw_reg <= em_in;
        sb_reg <= tc_in;
        // selector: auto-only pins it, emergency-follow forces manual
        if (auto_only) begin
          sel_man_reg <= 1'b0;
        end else if (em_in && em_follow && !em_sw_reg) begin
          sel_man_reg <= 1'b1;
        end else if (want_man) begin
          sel_man_reg <= 1'b1;
        end else if (want_auto && !(lock && em_in)) begin
          sel_man_reg <= 1'b0;
        end
        // output selection, standby first
        if (tc_in) begin
          BLOCK_OUTPUT_O <= TRACK_VARIABLE_INPUT_I;
          man_reg <= TRACK_VARIABLE_INPUT_I;
        end else if (em_in) begin
          BLOCK_OUTPUT_O <= BLOCK_OUTPUT_O;
          man_reg <= man_clamped;
        end else if (in_auto && !auto_only ? 1'b1 : (in_auto || auto_only) && start_cnt_reg == 2'h0) begin
          BLOCK_OUTPUT_O <= AUTO_IN_I;
          man_reg <= AUTO_IN_I;
        end else begin
          BLOCK_OUTPUT_O <= man_clamped;
          man_reg <= man_clamped;
        end
        // auto/not-auto status matches the output choice, made from the state before this scan
        AUTO_STATUS_OUT_O <= ~tc_in & ~em_in & (in_auto | auto_only) & (start_cnt_reg == 2'h0);
        NOT_AUTO_OUT_O <= ~(~tc_in & ~em_in & (in_auto | auto_only) & (start_cnt_reg == 2'h0));
        EMERGENCY_STATUS_OUT_O <= em_in;
        STANDBY_STATUS_OUT_O <= tc_in;
      end else if (man_wr_reg || knob_ev) begin
        man_reg <= man_clamped; // adjustment held until the scan uses it
      end
      MANUAL_STATUS_OUT_O <= sel_man_reg;
      MANUAL_LED_O <= sel_man_reg;
      AUTO_LED_O <= ~sel_man_reg;
    end
  end
  // ----------------------------------------------------------------
  // event display
  // ----------------------------------------------------------------
  amt_event u_em_event (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .active_i(em_sw_reg),
    .ack_i(ack_ev | ack_sw_reg[0]),
    .prio_i(prio_reg[2:0]),
    .flash_bar_o(EM_FLASH_BAR_O),
    .flash_led_o(EM_FLASH_LED_O),
    .steady_led_o(EM_STEADY_LED_O)
  );
  amt_event u_sb_event (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .active_i(sb_reg),
    .ack_i(ack_ev | ack_sw_reg[1]),
    .prio_i(prio_reg[6:4]),
    .flash_bar_o(SB_FLASH_BAR_O),
    .flash_led_o(SB_FLASH_LED_O),
    .steady_led_o(SB_STEADY_LED_O)
  );
endmodule

// [sim/amt_monitor.sv]
// amt_monitor.sv: port-level assertions for amt_top
// assumes one clock domain and a classic wishbone master
`timescale 1ns/1ps
module amt_monitor (
  // clock, reset, bus, start pins
  input logic CLK_I,
  input logic SYS_RST_I,
  input logic CYC_I,
  input logic STB_I,
  input logic ACK_O,
  input logic WARM_START_I,
  input logic COLD_START_I,
  // loop outputs and display
  input logic signed [15:0] BLOCK_OUTPUT_O,
  input logic AUTO_STATUS_OUT_O,
  input logic NOT_AUTO_OUT_O,
  input logic EMERGENCY_STATUS_OUT_O,
  input logic STANDBY_STATUS_OUT_O,
  input logic AUTO_LED_O,
  input logic MANUAL_LED_O,
  input logic EM_FLASH_BAR_O,
  input logic EM_FLASH_LED_O,
  input logic EM_STEADY_LED_O,
  input logic SB_FLASH_BAR_O,
  input logic SB_FLASH_LED_O
);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // a taken request is answered on the next edge
  property p_ack_next; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus answer late");
  // ack is a single-cycle pulse
  property p_ack_one; ACK_O |=> !ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  // reset leaves output zero and the loop not in auto
  property p_rst; disable iff (1'b0) SYS_RST_I |=> BLOCK_OUTPUT_O == 16'sh0000 && NOT_AUTO_OUT_O && !ACK_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // auto and not-auto are exact complements
  property p_as_na; AUTO_STATUS_OUT_O != NOT_AUTO_OUT_O; endproperty
  a_as_na: assert property (p_as_na) else $error("auto status pair broken");
  // standby status is never shown together with auto status
  property p_sb_na; STANDBY_STATUS_OUT_O |-> !AUTO_STATUS_OUT_O; endproperty
  a_sb_na: assert property (p_sb_na) else $error("standby shown as auto");
  // emergency without standby is never auto
  property p_em_na; EMERGENCY_STATUS_OUT_O && !STANDBY_STATUS_OUT_O |-> !AUTO_STATUS_OUT_O; endproperty
  a_em_na: assert property (p_em_na) else $error("emergency shown as auto");
  // output frozen while emergency lasts (no start event, no standby)
  property p_hold;
    EMERGENCY_STATUS_OUT_O && $past(EMERGENCY_STATUS_OUT_O) && !STANDBY_STATUS_OUT_O
    && !$past(STANDBY_STATUS_OUT_O) && !$past(WARM_START_I) && !$past(COLD_START_I) |-> $stable(BLOCK_OUTPUT_O);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved in emergency");
  // the two selector lamps are never lit together or both dark
  property p_leds; AUTO_LED_O != MANUAL_LED_O; endproperty
  a_leds: assert property (p_leds) else $error("selector lamps inconsistent");
  // bargraph flashing only comes with indicator flashing
  property p_em_bar; EM_FLASH_BAR_O |-> EM_FLASH_LED_O; endproperty
  a_em_bar: assert property (p_em_bar) else $error("emergency bar without lamp");
  property p_sb_bar; SB_FLASH_BAR_O |-> SB_FLASH_LED_O; endproperty
  a_sb_bar: assert property (p_sb_bar) else $error("standby bar without lamp");
  // steady lighting belongs to a non-flashing priority
  property p_em_st; EM_STEADY_LED_O |-> !EM_FLASH_LED_O; endproperty
  a_em_st: assert property (p_em_st) else $error("steady and flashing together");
endmodule
bind amt_top amt_monitor u_mon (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .WARM_START_I(WARM_START_I), .COLD_START_I(COLD_START_I), .BLOCK_OUTPUT_O(BLOCK_OUTPUT_O),
  .AUTO_STATUS_OUT_O(AUTO_STATUS_OUT_O), .NOT_AUTO_OUT_O(NOT_AUTO_OUT_O),
  .EMERGENCY_STATUS_OUT_O(EMERGENCY_STATUS_OUT_O), .STANDBY_STATUS_OUT_O(STANDBY_STATUS_OUT_O),
  .AUTO_LED_O(AUTO_LED_O), .MANUAL_LED_O(MANUAL_LED_O), .EM_FLASH_BAR_O(EM_FLASH_BAR_O),
  .EM_FLASH_LED_O(EM_FLASH_LED_O), .EM_STEADY_LED_O(EM_STEADY_LED_O), .SB_FLASH_BAR_O(SB_FLASH_BAR_O),
  .SB_FLASH_LED_O(SB_FLASH_LED_O));

// [sim/amt_ctl_model.sv]
// amt_ctl_model.sv: upstream loop controller feeding the auto input
// assumes the same clock as the block; registered output
`timescale 1ns/1ps
module amt_ctl_model (
  // clock and reset
  input logic clk_i,
  input logic rst_i,
  // setpoint, tracking and block feedback
  input logic trk_i,
  input logic signed [15:0] sp_i,
  input logic signed [15:0] y_i,
  // controller output
  output logic signed [15:0] u_o
);
  // tracking the block output lets a later switch to auto be bumpless
  always @(posedge clk_i) begin
    if (rst_i) u_o <= 16'sh0000;
    else u_o <= trk_i ? y_i : sp_i;
  end
endmodule

// [sim/amt_tb.sv]
// amt_tb.sv: self-checking bench for amt_top
// assumes the controller model on the auto input and a wishbone master here
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [15:0] a; logic tc; logic [15:0] tv; logic em;
    logic [15:0] o; logic as_; logic ss; logic es; logic ms;} amt_row_t;
  logic clk, rst, cyc, stb, we, ack, scan, warm, cold, em, tc, kstep, kcw, amb, ackb, trk;
  logic as_o, na_o, ms_o, es_o, ss_o, aled, mled, efb, efl, esl, sfb, sfl, ssl;
  logic [3:0] sel;
  logic [5:0] adr;
  logic [31:0] dat_w, dat_r, q;
  logic signed [15:0] sp, ain, rlo, rhi, tv, y;
  int errors, tests_run, cycles;
  // ordinary selection cases: inputs, then expected output and status
  amt_row_t rows [5] = '{'{16'h1000, 0, 16'h0000, 0, 16'h1000, 1, 0, 0, 0},
    '{16'h1200, 1, 16'h0500, 0, 16'h0500, 0, 1, 0, 0}, '{16'h1200, 1, 16'h0600, 1, 16'h0600, 0, 1, 1, 0},
    '{16'h1300, 0, 16'h0000, 1, 16'h0600, 0, 0, 1, 0}, '{16'h1300, 0, 16'h0000, 0, 16'h1300, 1, 0, 0, 0}};
  amt_ctl_model u_ctl (.clk_i(clk), .rst_i(rst), .trk_i(trk), .sp_i(sp), .y_i(y), .u_o(ain));
  amt_top dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .SCAN_I(scan), .WARM_START_I(warm), .COLD_START_I(cold),
    .AUTO_IN_I(ain), .RANGE_LO_I(rlo), .RANGE_HI_I(rhi), .EMERGENCY_INPUT_I(em), .TRACK_COMMAND_INPUT_I(tc),
    .TRACK_VARIABLE_INPUT_I(tv), .KNOB_STEP_I(kstep), .KNOB_CW_I(kcw), .AM_BUTTON_I(amb), .ACK_BUTTON_I(ackb),
    .BLOCK_OUTPUT_O(y), .AUTO_STATUS_OUT_O(as_o), .NOT_AUTO_OUT_O(na_o), .MANUAL_STATUS_OUT_O(ms_o),
    .EMERGENCY_STATUS_OUT_O(es_o), .STANDBY_STATUS_OUT_O(ss_o), .AUTO_LED_O(aled), .MANUAL_LED_O(mled),
    .EM_FLASH_BAR_O(efb), .EM_FLASH_LED_O(efl), .EM_STEADY_LED_O(esl), .SB_FLASH_BAR_O(sfb),
    .SB_FLASH_LED_O(sfl), .SB_STEADY_LED_O(ssl));
  // ---------------------------------------------
  // clock, timeout and report
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run is under a thousand cycles; the ceiling cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic st(input logic [15:0] o, input logic a, input logic m);
    chk(y, o);
    chk(as_o, a);
    chk(ms_o, m);
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      errors++;
      end_sim;
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // lead time covers the two-stage pin synchronisers
  task automatic scan_n(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      scan <= 1'b1;
      repeat (6) @(posedge clk);
      scan <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic knob(input logic cw, input int n);
    repeat (n) begin
      kcw <= cw;
      kstep <= 1'b1;
      repeat (4) @(posedge clk);
      kstep <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {cyc, stb, we, scan, warm, cold, em, tc, kstep, kcw, amb, ackb, trk} = '0;
    sel = 4'hf;
    adr = 6'h00;
    dat_w = 32'h0;
    {sp, rlo, rhi, tv} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    st(16'h0000, 0, 1);
    wb(0, 4'h1, 0); chk(q[15:0], 16'h0008);
    wb(0, 4'h6, 0); chk(q[15:0], 16'h0000);
    wb(1, 4'h7, 32'h1234); wb(0, 4'h7, 0); chk(q[15:0], 16'h0000);
    wb(0, 4'h0, 0); chk(q[15:0], 16'h0000);
    wb(1, 4'h0, 32'h1);
    foreach (rows[i]) begin
      sp <= rows[i].a;
      tc <= rows[i].tc;
      tv <= rows[i].tv;
      em <= rows[i].em;
      scan_n(2);
      st(rows[i].o, rows[i].as_, rows[i].ms);
      chk(ss_o, rows[i].ss);
      chk(es_o, rows[i].es);
    end
    wb(0, 4'h3, 0); chk(q[15:0], 16'h1300);
    wb(1, 4'h0, 32'h2); scan_n(2); st(16'h1300, 0, 1);
    knob(1, 3); scan_n(1); chk(y, 16'h1303);
    wb(1, 4'h1, 32'h0208); knob(0, 1); scan_n(1); chk(y, 16'h129f);
    wb(1, 4'h1, 32'h0200); knob(1, 1); scan_n(1); chk(y, 16'h123b);
    wb(1, 4'h1, 32'h0008); wb(1, 4'h3, 32'h7000); scan_n(1); chk(y, 16'h2af8);
    wb(1, 4'h3, 32'hf000); scan_n(1); chk(y, 16'hfc18);
    rhi <= 16'h03e8; wb(1, 4'h1, 32'h0048); wb(1, 4'h3, 32'h7000); scan_n(1); chk(y, 16'h044c);
    wb(1, 4'h1, 32'h0038); wb(1, 4'h0, 32'h1); scan_n(2); st(16'h1300, 1, 0);
    em <= 1'b1; scan_n(2); st(16'h1300, 0, 1); chk(mled, 1);
    wb(1, 4'h0, 32'h1); scan_n(1); chk(ms_o, 1);
    em <= 1'b0; scan_n(2); st(16'h1300, 0, 1); chk(es_o, 0);
    amb <= 1'b1; repeat (6) @(posedge clk); amb <= 1'b0; scan_n(2); st(16'h1300, 1, 0);
    wb(1, 4'h1, 32'h0009); wb(1, 4'h0, 32'h2); scan_n(1); st(16'h1300, 1, 0);
    wb(1, 4'h1, 32'h0008); wb(1, 4'h6, 32'h51); em <= 1'b1; scan_n(1); chk(efb, 1);
    em <= 1'b0; scan_n(2); chk(efb, 1);
    ackb <= 1'b1; repeat (6) @(posedge clk); ackb <= 1'b0; scan_n(1); chk(efl, 0);
    tc <= 1'b1; tv <= 16'h1300; scan_n(1); chk(ssl, 1); chk(sfl, 0);
    tc <= 1'b0; scan_n(1); chk(ssl, 0);
    wb(1, 4'h1, 32'h000a); warm <= 1'b1; @(posedge clk); warm <= 1'b0; sp <= 16'h0800;
    scan_n(2); chk(y, 16'h1300);
    scan_n(1); st(16'h0800, 1, 0);
    wb(1, 4'h1, 32'h000c); wb(1, 4'h2, 32'h0123); cold <= 1'b1; @(posedge clk); cold <= 1'b0;
    scan_n(1); st(16'h0123, 0, 1);
    end_sim;
  end
endmodule
